// ==== logic/cnb_pkg.sv ====
// Shared constants, carriers and helpers for the command register bank
package cnb_pkg;
   // Command codes of the register bank
   localparam logic [7:0] CMD_POWER_ENABLE = 8'h01;
   localparam logic [7:0] CMD_ENABLE_SOURCE = 8'h02;
   localparam logic [7:0] CMD_FAULT_CLEAR = 8'h03;
   localparam logic [7:0] CMD_NVM_SAVE = 8'h15;
   localparam logic [7:0] CMD_NVM_LOAD = 8'h16;
   localparam logic [7:0] CMD_SWITCH_RATE = 8'h33;
   // Field positions
   localparam int PWR_EN_BIT = 7;
   localparam int SRC_LSB = 5;
   localparam int TRIG_BIT = 0;
   localparam int STS_INVALID_BIT = 7;
   // Values after reset
   localparam logic PWR_EN_RST = 1'h0;
   localparam logic [2:0] SRC_RST = 3'h2;
   localparam logic [1:0] RATE_RST = 2'h1;
   localparam logic [6:0] ADDR_NVM_RST = 7'h10;
   localparam logic [7:0] STATUS_RST = 8'h00;
   // Enable-source codes
   typedef enum logic [2:0] {
      SRC_ALWAYS = 3'h0,
      SRC_SERIAL = 3'h1,
      SRC_PIN = 3'h2,
      SRC_BOTH = 3'h3
   } cnb_src_t;
   // Voltage-ID link command codes
   localparam logic [7:0] VID_SET_FAST = 8'h01;
   localparam logic [7:0] VID_VALUE_READ = 8'h07;
   localparam logic [7:0] VID_WORKING_POINT = 8'h09;
   // Synchroniser lanes
   localparam int SY_EN = 0;
   localparam int SY_OK = 1;
   localparam int SY_LATCH = 2;
   localparam int SY_FLT = 3;
   localparam int SYNC_W = 10;
   // User-store items
   localparam int MEM_DEPTH = 4;
   localparam logic [1:0] ITEM_SRC = 2'h0;
   localparam logic [1:0] ITEM_RATE = 2'h1;
   localparam logic [1:0] ITEM_ADDR = 2'h2;
   localparam logic [31:0] MEM_INIT = {8'h00, 1'h0, ADDR_NVM_RST,
      6'h00, RATE_RST, 5'h00, SRC_RST};
   // Timing at the 200 MHz core clock
   localparam int CLK_MHZ = 200;
   localparam int CLK_KHZ = CLK_MHZ * 1000;
   localparam int STORE_TIME_MS = 150;
   localparam int STORE_CYCLES = STORE_TIME_MS * CLK_KHZ;
   localparam int LOAD_TIME_US = 10;
   localparam int LOAD_CYCLES = LOAD_TIME_US * CLK_MHZ;
   localparam int BUSY_W = 25;
   localparam int RATE_KHZ_0 = 600;
   localparam int RATE_KHZ_1 = 800;
   localparam int RATE_KHZ_2 = 1000;
   localparam int RATE_KHZ_3 = 1200;
   // Sequencer phases
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_SAVE = 3'h1,
      PH_SAVE_WAIT = 3'h2,
      PH_LOAD = 3'h3,
      PH_LOAD_WAIT = 3'h4
   } cnb_phase_t;
   // Decoded serial frame and its answer
   typedef struct packed {
      logic valid;
      logic write;
      logic has_data;
      logic [7:0] code;
      logic [7:0] data;
   } cnb_req_t;
   typedef struct packed {
      logic done;
      logic ack;
      logic [7:0] data;
   } cnb_rsp_t;
   typedef struct packed {
      logic valid;
      logic [7:0] code;
   } cnb_vid_req_t;
   typedef struct packed {
      logic accept;
      logic reject;
   } cnb_vid_rsp_t;
   // Switching period in core cycles, rounded down
   function automatic logic [8:0] rate_period(input logic [1:0] code);
      case (code)
         2'h0: rate_period = 9'(CLK_KHZ / RATE_KHZ_0);
         2'h1: rate_period = 9'(CLK_KHZ / RATE_KHZ_1);
         2'h2: rate_period = 9'(CLK_KHZ / RATE_KHZ_2);
         default: rate_period = 9'(CLK_KHZ / RATE_KHZ_3);
      endcase
   endfunction
endpackage

// ==== logic/cnb_store_mem.sv ====
// Small user store memory holding the saved settings
`timescale 1ns/10ps
module cnb_store_mem
   import cnb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic we_in,
   input wire logic [1:0] waddr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [1:0] raddr_in,
   output logic [7:0] rdata_out
);
   typedef struct packed {
      logic [MEM_DEPTH-1:0][7:0] words;
      logic [7:0] rdata;
   } cnb_mem_t;

   cnb_mem_t st_ff;
   cnb_mem_t nxt_st;

   // Write port plus registered read, one word per cycle
   always_comb begin
      nxt_st = st_ff;
      if (we_in) begin
         nxt_st.words[waddr_in] = wdata_in;
      end
      nxt_st.rdata = st_ff.words[raddr_in];
   end

   // Power-on reset stands in for the factory content
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_ff.words <= MEM_INIT;
         st_ff.rdata <= 8'h00;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata_out = st_ff.rdata;
endmodule // cnb_store_mem

// ==== logic/cnb_top.sv ====
// Command register bank: conversion enable, faults, user store, rate
// Summary of operation
// - Accept link codes 01h-07h and 09h
// - Bit 7 of 01h requests conversion
// - Reserved bits always read as zero
// - Bits 7:5 of 02h choose turn-on source
// - Code 011b needs pin and bit both
// - Codes 100b-111b acknowledged, state unchanged
// - Bad source code flags invalid data
// - Send-byte 03h clears all status bits
// - Clearing never restarts latched-off converter
// - Live fault sets its bit again
// - Bit 0 triggers action, self-clearing
// - 15h copies settings into user store
// - Commands ignored while store runs
// - 16h loads stored settings, address too
// - All frames NACKed while restore runs
// - Restore while switching is NACKed, ACKed if store runs
// - 33h selects switching frequency
// - Codes 0-3 give 0.6-1.2 MHz
`timescale 1ns/10ps
module cnb_top
   import cnb_pkg::*;
#(
   parameter int STORE_HOLD_CYCLES = STORE_CYCLES
) (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire cnb_req_t CMD_REQ_IN,
   output cnb_rsp_t CMD_RSP_OUT,
   input wire cnb_vid_req_t VID_REQ_IN,
   output cnb_vid_rsp_t VID_RSP_OUT,
   input wire logic EN_PIN_IN,
   input wire logic SUPPLY_OK_IN,
   input wire logic FAULT_LATCHED_IN,
   input wire logic [6:0] FAULT_ACTIVE_IN,
   input wire logic [6:0] ADDR_STRAP_IN,
   output logic CONV_RUN_OUT,
   output logic SW_TICK_OUT,
   output logic [1:0] RATE_CODE_OUT,
   output logic [7:0] STATUS_OUT,
   output logic [6:0] BUS_ADDR_OUT,
   output logic NVM_BUSY_OUT
);
   localparam logic [BUSY_W-1:0] STORE_LAST =
      BUSY_W'(STORE_HOLD_CYCLES - 1);
   localparam logic [BUSY_W-1:0] LOAD_LAST = BUSY_W'(LOAD_CYCLES - 1);

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [SYNC_W-1:0] flt;
      logic run_en;
      logic [2:0] src;
      logic [1:0] rate;
      logic [6:0] addr;
      logic addr_caught;
      logic [7:0] status;
      logic conv_run;
      cnb_phase_t phase;
      logic busy;
      logic [1:0] item;
      logic rd_pend;
      logic [1:0] rd_item;
      logic [BUSY_W-1:0] wait_cnt;
      logic [8:0] sw_cnt;
      logic sw_tick;
      cnb_rsp_t rsp;
      cnb_vid_rsp_t vid;
   } cnb_state_t;

   cnb_state_t st_ff;
   cnb_state_t nxt_st;

   logic [SYNC_W-1:0] pin_vec;
   logic run_req;
   logic inv_set;
   logic clr_all;
   logic mem_we;
   logic [1:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [1:0] mem_raddr;
   logic [7:0] mem_rdata;

   // trigger bit test
   // A data-less send-byte counts as writing a one
   function automatic logic trig_hit(input cnb_req_t r);
      trig_hit = !r.has_data || r.data[TRIG_BIT];
   endfunction

   function automatic logic vid_ok(input logic [7:0] code);
      vid_ok = (code >= VID_SET_FAST && code <= VID_VALUE_READ) ||
         (code == VID_WORKING_POINT);
   endfunction

   // Pins and fault lines from outside this clock domain
   assign pin_vec = {FAULT_ACTIVE_IN, FAULT_LATCHED_IN,
      SUPPLY_OK_IN, EN_PIN_IN};

   // Next-state logic for the whole bank
   always_comb begin
      nxt_st = st_ff;
      run_req = 1'b0;
      inv_set = 1'b0;
      clr_all = 1'b0;
      mem_we = 1'b0;
      mem_waddr = ITEM_SRC;
      mem_wdata = 8'h00;
      mem_raddr = ITEM_SRC;

      // Three-stage synchroniser, lane changes once stages 2 and 3 agree
      nxt_st.s1 = pin_vec;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < SYNC_W; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.flt[i] = st_ff.s3[i];
         end
      end

      // Strap address is caught once, the cycle after reset release
      if (!st_ff.addr_caught) begin
         nxt_st.addr = ADDR_STRAP_IN;
         nxt_st.addr_caught = 1'b1;
      end

      // Answers are one-cycle pulses
      nxt_st.rsp = '0;
      nxt_st.vid = '0;

      if (VID_REQ_IN.valid) begin
         nxt_st.vid.accept = vid_ok(VID_REQ_IN.code);
         nxt_st.vid.reject = !vid_ok(VID_REQ_IN.code);
      end

      // Serial frame decode
      if (CMD_REQ_IN.valid) begin
         nxt_st.rsp.done = 1'b1;
         if (st_ff.phase == PH_LOAD || st_ff.phase == PH_LOAD_WAIT) begin
            nxt_st.rsp.ack = 1'b0;
         // store ignores frames
         // Acknowledged on the wire but without any effect
         end else if (st_ff.phase != PH_IDLE) begin
            nxt_st.rsp.ack = 1'b1;
         end else begin
            case (CMD_REQ_IN.code)
               CMD_POWER_ENABLE: begin
                  nxt_st.rsp.ack = !CMD_REQ_IN.write ||
                     CMD_REQ_IN.has_data;
                  if (CMD_REQ_IN.write && CMD_REQ_IN.has_data) begin
                     nxt_st.run_en = CMD_REQ_IN.data[PWR_EN_BIT];
                  end
                  if (!CMD_REQ_IN.write) begin
                     nxt_st.rsp.data = {st_ff.run_en, 7'h00};
                  end
               end
               CMD_ENABLE_SOURCE: begin
                  nxt_st.rsp.ack = !CMD_REQ_IN.write ||
                     CMD_REQ_IN.has_data;
                  if (CMD_REQ_IN.write && CMD_REQ_IN.has_data) begin
                     if (CMD_REQ_IN.data[PWR_EN_BIT]) begin
                        inv_set = 1'b1;
                     end else begin
                        nxt_st.src = CMD_REQ_IN.data[PWR_EN_BIT:SRC_LSB];
                     end
                  end
                  if (!CMD_REQ_IN.write) begin
                     nxt_st.rsp.data = {st_ff.src, 5'h00};
                  end
               end
               CMD_FAULT_CLEAR: begin
                  nxt_st.rsp.ack = CMD_REQ_IN.write;
                  if (CMD_REQ_IN.write && trig_hit(CMD_REQ_IN)) begin
                     clr_all = 1'b1;
                  end
               end
               CMD_NVM_SAVE: begin
                  nxt_st.rsp.ack = CMD_REQ_IN.write;
                  if (CMD_REQ_IN.write && trig_hit(CMD_REQ_IN)) begin
                     nxt_st.phase = PH_SAVE;
                     nxt_st.item = ITEM_SRC;
                  end
               end
               CMD_NVM_LOAD: begin
                  nxt_st.rsp.ack = CMD_REQ_IN.write && !st_ff.conv_run;
                  if (CMD_REQ_IN.write && !st_ff.conv_run &&
                        trig_hit(CMD_REQ_IN)) begin
                     nxt_st.phase = PH_LOAD;
                     nxt_st.item = ITEM_SRC;
                  end
               end
               CMD_SWITCH_RATE: begin
                  nxt_st.rsp.ack = !CMD_REQ_IN.write ||
                     CMD_REQ_IN.has_data;
                  if (CMD_REQ_IN.write && CMD_REQ_IN.has_data) begin
                     nxt_st.rate = CMD_REQ_IN.data[1:0];
                  end
                  if (!CMD_REQ_IN.write) begin
                     nxt_st.rsp.data = {6'h00, st_ff.rate};
                  end
               end
               default: begin
                  nxt_st.rsp.ack = 1'b0;
               end
            endcase
         end
      end

      // Apply a word read from the user store the cycle before
      if (st_ff.rd_pend) begin
         nxt_st.rd_pend = 1'b0;
         case (st_ff.rd_item)
            ITEM_SRC: nxt_st.src = mem_rdata[2:0];
            ITEM_RATE: nxt_st.rate = mem_rdata[1:0];
            default: nxt_st.addr = mem_rdata[6:0];
         endcase
      end

      // User store sequencer, one item per cycle then a hold time
      case (st_ff.phase)
         PH_IDLE: begin
            nxt_st.wait_cnt = '0;
         end
         PH_SAVE: begin
            mem_we = 1'b1;
            mem_waddr = st_ff.item;
            case (st_ff.item)
               ITEM_SRC: mem_wdata = {5'h00, st_ff.src};
               ITEM_RATE: mem_wdata = {6'h00, st_ff.rate};
               default: mem_wdata = {1'b0, st_ff.addr};
            endcase
            nxt_st.item = st_ff.item + 2'h1;
            if (st_ff.item == ITEM_ADDR) begin
               nxt_st.phase = PH_SAVE_WAIT;
            end
         end
         PH_SAVE_WAIT: begin
            nxt_st.wait_cnt = st_ff.wait_cnt + 1'b1;
            if (st_ff.wait_cnt >= STORE_LAST) begin
               nxt_st.phase = PH_IDLE;
            end
         end
         PH_LOAD: begin
            mem_raddr = st_ff.item;
            nxt_st.rd_pend = 1'b1;
            nxt_st.rd_item = st_ff.item;
            nxt_st.item = st_ff.item + 2'h1;
            if (st_ff.item == ITEM_ADDR) begin
               nxt_st.phase = PH_LOAD_WAIT;
            end
         end
         PH_LOAD_WAIT: begin
            nxt_st.wait_cnt = st_ff.wait_cnt + 1'b1;
            if (st_ff.wait_cnt >= LOAD_LAST) begin
               nxt_st.phase = PH_IDLE;
            end
         end
         default: begin
            nxt_st.phase = PH_IDLE;
         end
      endcase

      // Busy flag kept in a flop so the output needs no decode
      nxt_st.busy = (nxt_st.phase != PH_IDLE);

      case (st_ff.src)
         SRC_ALWAYS: run_req = 1'b1;
         SRC_SERIAL: run_req = st_ff.run_en;
         SRC_PIN: run_req = st_ff.flt[SY_EN];
         // both must request
         // Either side dropping its request stops conversion
         SRC_BOTH: run_req = st_ff.run_en & st_ff.flt[SY_EN];
         default: run_req = 1'b0;
      endcase

      // latch-off holds
      // Status clearing never touches the latch, only its own input does
      nxt_st.conv_run = run_req & st_ff.flt[SY_OK] &
         !st_ff.flt[SY_LATCH];

      // live fault resets
      // The set term is ORed after the clear so a fault is never lost
      nxt_st.status = clr_all ? STATUS_RST : st_ff.status;
      nxt_st.status[6:0] = nxt_st.status[6:0] | st_ff.flt[SYNC_W-1:SY_FLT];
      if (inv_set) begin
         nxt_st.status[STS_INVALID_BIT] = 1'b1;
      end

      // switching period tick
      // A rate change takes effect at the next period boundary at latest
      nxt_st.sw_tick = 1'b0;
      if (!st_ff.conv_run) begin
         nxt_st.sw_cnt = 9'h000;
      end else if (st_ff.sw_cnt >= rate_period(st_ff.rate) - 9'h001) begin
         nxt_st.sw_cnt = 9'h000;
         nxt_st.sw_tick = 1'b1;
      end else begin
         nxt_st.sw_cnt = st_ff.sw_cnt + 9'h001;
      end
   end

   // State register, synchronous reset
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         st_ff <= '0;
         st_ff.run_en <= PWR_EN_RST;
         st_ff.src <= SRC_RST;
         st_ff.rate <= RATE_RST;
         st_ff.status <= STATUS_RST;
         st_ff.phase <= PH_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // User store items live in their own memory
   cnb_store_mem u_store (
      .clk_in(CLOCK_IN),
      .rst_in(RST_IN),
      .we_in(mem_we),
      .waddr_in(mem_waddr),
      .wdata_in(mem_wdata),
      .raddr_in(mem_raddr),
      .rdata_out(mem_rdata)
   );

   // Outputs straight from the state register
   assign CMD_RSP_OUT = st_ff.rsp;
   assign VID_RSP_OUT = st_ff.vid;
   assign CONV_RUN_OUT = st_ff.conv_run;
   assign SW_TICK_OUT = st_ff.sw_tick;
   assign RATE_CODE_OUT = st_ff.rate;
   assign STATUS_OUT = st_ff.status;
   assign BUS_ADDR_OUT = st_ff.addr;
   assign NVM_BUSY_OUT = st_ff.busy;
endmodule // cnb_top

// ==== bench/cnb_host_model.sv ====
// Host model driving serial frames and link commands into the bank
`timescale 1ns/10ps
module cnb_host_model
   import cnb_pkg::*;
(
   input wire logic clk_in,
   input wire cnb_rsp_t rsp_in,
   input wire cnb_vid_rsp_t vid_rsp_in,
   output cnb_req_t req_out,
   output cnb_vid_req_t vid_out
);
   // Idle fields carry junk so stale codes are never trusted
   initial begin
      req_out = '{1'h0, 1'h0, 1'h0, 8'hA5, 8'h5A};
      vid_out = '{1'h0, 8'h3C};
   end

   // One frame held for one edge; a missing done turns ack unknown
   task automatic frame(input logic wr, hd, input logic [7:0] cd, dt,
         output logic ak, output logic [7:0] rd);
      @(posedge clk_in);
      #1 req_out = '{1'h1, wr, hd, cd, dt};
      @(posedge clk_in);
      #1 req_out = '{1'h0, !wr, !hd, ~cd, ~dt};
      ak = rsp_in.done ? rsp_in.ack : 1'hx;
      rd = rsp_in.data;
   endtask

   // One link command; answer is {accept, reject}
   task automatic link(input logic [7:0] cd, output logic [1:0] ar);
      @(posedge clk_in);
      #1 vid_out = '{1'h1, cd};
      @(posedge clk_in);
      #1 vid_out = '{1'h0, ~cd};
      ar = {vid_rsp_in.accept, vid_rsp_in.reject};
   endtask
endmodule // cnb_host_model

// ==== bench/cnb_props.sv ====
// Checker of command, link, status and run behaviour at the bank ports
`timescale 1ns/10ps
module cnb_props
   import cnb_pkg::*;
#(
   parameter int STORE_HOLD_CYCLES = STORE_CYCLES
) (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire cnb_req_t CMD_REQ_IN,
   input wire cnb_rsp_t CMD_RSP_OUT,
   input wire cnb_vid_req_t VID_REQ_IN,
   input wire cnb_vid_rsp_t VID_RSP_OUT,
   input wire logic FAULT_LATCHED_IN,
   input wire logic [6:0] FAULT_ACTIVE_IN,
   input wire logic CONV_RUN_OUT,
   input wire logic SW_TICK_OUT,
   input wire logic [1:0] RATE_CODE_OUT,
   input wire logic [7:0] STATUS_OUT,
   input wire logic NVM_BUSY_OUT
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);

   // Decoded frame kinds
   logic rq;
   logic wq;
   logic [7:0] cd;
   logic vok;
   assign rq = CMD_REQ_IN.valid & !CMD_REQ_IN.write;
   assign wq = CMD_REQ_IN.valid & CMD_REQ_IN.write;
   assign cd = CMD_REQ_IN.code;
   assign vok = VID_REQ_IN.code inside {[8'h01:8'h07], 8'h09};

   // Tick gap tracker; a rate change or stop voids the running gap
   logic [8:0] gap_ff;
   logic seen_ff;
   logic [1:0] rate_ff;
   logic [8:0] want;
   always_comb begin
      case (rate_ff)
         2'h0: want = 9'h14D;
         2'h1: want = 9'h0FA;
         2'h2: want = 9'h0C8;
         default: want = 9'h0A6;
      endcase
   end
   always_ff @(posedge CLOCK_IN) begin
      rate_ff <= RATE_CODE_OUT;
      gap_ff <= SW_TICK_OUT ? 9'h001 : gap_ff + 9'h001;
      seen_ff <= (SW_TICK_OUT | seen_ff) & CONV_RUN_OUT & !RST_IN
         & (RATE_CODE_OUT == rate_ff);
   end

   frame_answer_a:
      assert property (CMD_REQ_IN.valid |=> CMD_RSP_OUT.done)
      else $error("frame not answered");
   link_accept_a:
      assert property (VID_REQ_IN.valid && vok |=>
         VID_RSP_OUT.accept && !VID_RSP_OUT.reject)
      else $error("listed link code not accepted");
   link_reject_a:
      assert property (VID_REQ_IN.valid && !vok |=>
         VID_RSP_OUT.reject && !VID_RSP_OUT.accept)
      else $error("unlisted link code not rejected");
   rsvd_enable_a:
      assert property (rq && cd == CMD_POWER_ENABLE |=>
         CMD_RSP_OUT.data[6:0] == 7'h00)
      else $error("enable reserved bits set");
   rsvd_source_a:
      assert property (rq && cd == CMD_ENABLE_SOURCE |=>
         CMD_RSP_OUT.data[4:0] == 5'h00)
      else $error("source reserved bits set");
   rsvd_rate_a:
      assert property (rq && cd == CMD_SWITCH_RATE |=>
         CMD_RSP_OUT.data[7:2] == 6'h00)
      else $error("rate reserved bits set");
   restore_refuse_a:
      assert property (wq && cd == CMD_NVM_LOAD && CONV_RUN_OUT |=>
         !CMD_RSP_OUT.ack)
      else $error("restore while running acked");
   store_busy_a:
      assert property (wq && !CMD_REQ_IN.has_data && cd == CMD_NVM_SAVE
         && !NVM_BUSY_OUT |=> CMD_RSP_OUT.ack && NVM_BUSY_OUT)
      else $error("store did not start");
   fault_sets_a:
      assert property (FAULT_ACTIVE_IN[0] [*8] |-> STATUS_OUT[0])
      else $error("live fault not flagged");
   latched_off_a:
      assert property (FAULT_LATCHED_IN [*8] |-> !CONV_RUN_OUT)
      else $error("latched converter runs");
   tick_period_a:
      assert property (SW_TICK_OUT && seen_ff && RATE_CODE_OUT == rate_ff
         |-> gap_ff == want)
      else $error("switching period wrong");
endmodule // cnb_props

bind cnb_top cnb_props #(
   .STORE_HOLD_CYCLES(STORE_HOLD_CYCLES)
) u_cnb_props (
   .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .CMD_REQ_IN(CMD_REQ_IN),
   .CMD_RSP_OUT(CMD_RSP_OUT), .VID_REQ_IN(VID_REQ_IN),
   .VID_RSP_OUT(VID_RSP_OUT), .FAULT_LATCHED_IN(FAULT_LATCHED_IN),
   .FAULT_ACTIVE_IN(FAULT_ACTIVE_IN), .CONV_RUN_OUT(CONV_RUN_OUT),
   .SW_TICK_OUT(SW_TICK_OUT), .RATE_CODE_OUT(RATE_CODE_OUT),
   .STATUS_OUT(STATUS_OUT), .NVM_BUSY_OUT(NVM_BUSY_OUT)
);

// ==== bench/cnb_top_test.sv ====
// Self-checking bench for the command register bank
`timescale 1ns/10ps
module cnb_top_test
   import cnb_pkg::*;
;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic en_pin = 1'h0;
   logic sup_ok = 1'h1;
   logic latched = 1'h0;
   logic [6:0] fact = 7'h00;
   logic [6:0] strap = 7'h2A;
   cnb_req_t req;
   cnb_rsp_t rsp;
   cnb_vid_req_t vreq;
   cnb_vid_rsp_t vrsp;
   logic run, tick_o, busy, ak, e;
   logic [1:0] rate, ar;
   logic [7:0] status, rd;
   logic [6:0] addr;
   logic [27:0] r;
   int n_tests = 0;
   int n_fail = 0;
   // Row: {write, has_data, ack, 0}, code, data, read data expected
   logic [27:0] rows [19] = '{28'h2010000, 28'h2020040, 28'hE018000,
      28'h2010080, 28'hE017F00, 28'h2010000, 28'hE023F00, 28'h2020020,
      28'hE02E000, 28'h2020020, 28'hE33FF00, 28'h2330003, 28'hE330200,
      28'h2330002, 28'h0030000, 28'hC441200, 28'h8010000, 28'h0150000,
      28'hE150000};

   // Store hold shortened so the run stays brief
   cnb_top #(.STORE_HOLD_CYCLES(20)) u_cnb_top (
      .CLOCK_IN(clk), .RST_IN(rst), .CMD_REQ_IN(req), .CMD_RSP_OUT(rsp),
      .VID_REQ_IN(vreq), .VID_RSP_OUT(vrsp), .EN_PIN_IN(en_pin),
      .SUPPLY_OK_IN(sup_ok), .FAULT_LATCHED_IN(latched),
      .FAULT_ACTIVE_IN(fact), .ADDR_STRAP_IN(strap), .CONV_RUN_OUT(run),
      .SW_TICK_OUT(tick_o), .RATE_CODE_OUT(rate), .STATUS_OUT(status),
      .BUS_ADDR_OUT(addr), .NVM_BUSY_OUT(busy));
   cnb_host_model u_cnb_host_model (.clk_in(clk), .rsp_in(rsp),
      .vid_rsp_in(vrsp), .req_out(req), .vid_out(vreq));

   initial begin
      forever #2.5 clk = !clk;
   end

   task results();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task check(input string nm, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Inputs move 1 ns after an edge, never on it
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task put(input logic [7:0] c, d);
      u_cnb_host_model.frame(1'h1, 1'h1, c, d, ak, rd);
      check("put_ack", 8'(ak), 8'h01);
   endtask

   task sb(input logic [7:0] c);
      u_cnb_host_model.frame(1'h1, 1'h0, c, 8'h00, ak, rd);
   endtask

   task wait_idle();
      int k;
      k = 0;
      while (busy !== 1'h0 && k < 3000) begin
         tick(1);
         k++;
      end
      check("busy", 8'(busy), 8'h00);
   endtask

   // Watchdog well beyond the expected 7k cycles
   initial begin
      #200000;
      n_fail++;
      results();
   end

   initial begin
      tick(3);
      rst = 1'h0;
      tick(4);
      check("rst_rate", 8'(rate), 8'h01);
      check("rst_addr", 8'(addr), 8'h2A);
      check("rst_stat", status, 8'h00);
      for (int i = 0; i < 19; i++) begin
         r = rows[i];
         u_cnb_host_model.frame(r[27], r[26], r[23:16], r[15:8], ak, rd);
         check("ack", 8'(ak), 8'(r[25]));
         if (r[25]) check("rdata", rd, r[7:0]);
      end
      check("save_off", 8'(busy), 8'h00);
      check("invalid", 8'(status[7]), 8'h01);
      fact = 7'h01;
      tick(10);
      sb(CMD_FAULT_CLEAR);
      tick(1);
      check("clr_live", status, 8'h01);
      fact = 7'h00;
      tick(10);
      put(CMD_FAULT_CLEAR, 8'h01);
      tick(1);
      check("clr", status, 8'h00);
      for (int s = 0; s < 4; s++) begin
         for (int m = 0; m < 4; m++) begin
            put(CMD_ENABLE_SOURCE, {s[2:0], 5'h00});
            put(CMD_POWER_ENABLE, {m[1], 7'h00});
            en_pin = m[0];
            tick(10);
            e = s == 0 | (s == 1 & m[1]) | (s == 2 & m[0]) |
               (s == 3 & m[0] & m[1]);
            check("run", 8'(run), 8'(e));
         end
      end
      en_pin = 1'h0;
      tick(10);
      check("pin_drop", 8'(run), 8'h00);
      put(CMD_ENABLE_SOURCE, 8'h20);
      put(CMD_POWER_ENABLE, 8'h80);
      sup_ok = 1'h0;
      tick(10);
      check("supply", 8'(run), 8'h00);
      sup_ok = 1'h1;
      latched = 1'h1;
      tick(10);
      sb(CMD_FAULT_CLEAR);
      tick(10);
      check("latched", 8'(run), 8'h00);
      latched = 1'h0;
      tick(10);
      check("rerun", 8'(run), 8'h01);
      for (int k = 0; k < 4; k++) begin
         put(CMD_SWITCH_RATE, 8'(k));
         tick(700);
         check("rate", 8'(rate), 8'(k));
      end
      sb(CMD_NVM_LOAD);
      check("load_run", 8'(ak), 8'h00);
      for (int c = 0; c < 11; c++) begin
         u_cnb_host_model.link(8'(c), ar);
         e = (c > 0 && c < 8) || c == 9;
         check("link", 8'(ar), {6'h00, e, !e});
      end
      put(CMD_POWER_ENABLE, 8'h00);
      tick(10);
      sb(CMD_NVM_LOAD);
      check("load_ack", 8'(ak), 8'h01);
      u_cnb_host_model.frame(1'h0, 1'h0, CMD_SWITCH_RATE, 8'h00, ak, rd);
      check("load_nack", 8'(ak), 8'h00);
      wait_idle();
      check("ld_addr", 8'(addr), 8'h10);
      check("ld_rate", 8'(rate), 8'h01);
      put(CMD_SWITCH_RATE, 8'h03);
      sb(CMD_NVM_SAVE);
      put(CMD_SWITCH_RATE, 8'h00);
      // Rate write during the store is acked but ignored; wait until the store is over
      wait_idle();
      check("ignored", 8'(rate), 8'h03);
      put(CMD_SWITCH_RATE, 8'h01);
      sb(CMD_NVM_LOAD);
      wait_idle();
      check("saved", 8'(rate), 8'h03);
      results();
   end
endmodule // cnb_top_test
